// ---- logic/ddrf_pkg.sv ----
// shared constants for the ddr access framing block
`default_nettype none
package ddrf_pkg;
	localparam int BANKS      = 8;
	localparam int BANK_W     = 3;
	localparam int ROW_W      = 14;   // 16,384 rows
	localparam int COL_W      = 11;   // 2048 columns in x16
	localparam int COL_W_X32  = 10;   // 1024 columns in x32
	localparam int DQ_W       = 32;   // column width in x32
	localparam int DQ_W_X16   = 16;   // column width in x16
	localparam int CA_W       = 10;
	localparam int PREFETCH   = 4;    // columns per core transfer
	localparam int CNT_W      = 5;
	localparam int FIFO_DEPTH = 8;
	localparam int MEM_AW     = 10;   // shadow store index width
	// opcode field of the rising half
	localparam int OP_LSB     = 0;
	localparam int OP_W       = 2;
	localparam int BA_LSB     = 2;
	localparam int HI_LSB     = 5;    // address bits in rising half
	localparam int HI_W       = 5;
	localparam int ROW_LO_W   = 9;    // row bits in falling half
	localparam int COL_LO_W   = 6;    // column bits in falling half
	localparam logic [1:0] OP_NOP = 2'h0;
	localparam logic [1:0] OP_ACT = 2'h1;
	localparam logic [1:0] OP_WR  = 2'h2;
	localparam logic [1:0] OP_RD  = 2'h3;
	localparam logic [1:0] BL_4   = 2'h0;
	localparam logic [1:0] BL_8   = 2'h1;
	localparam logic [4:0] CNT_STEP = 5'h02;  // two columns per clock
	localparam logic [4:0] CNT_ZERO = 5'h00;
	typedef enum logic [1:0] {DDRF_IDLE, DDRF_READ, DDRF_WRITE} ddrf_state_e;
endpackage
`default_nettype wire

// ---- logic/ddrf_fifo.sv ----
// write data fifo with valid and ready on both sides
`default_nettype none
`timescale 1ns/100ps
module ddrf_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys_in,
	input  wire logic             nrst_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output var  logic             in_ready_out,
	output var  logic             out_valid_out,
	output var  logic [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             push;
	logic             pop;

	// handshakes and occupancy
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign count_next    = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign out_valid_out = (count_reg != '0);
	assign out_data_out  = store[rd_ptr_reg];

	// pointers, count and registered ready
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_ptr_reg   <= '0;
			rd_ptr_reg   <= '0;
			count_reg    <= '0;
			in_ready_out <= 1'b0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg    <= count_next;
			in_ready_out <= (count_next != (AW+1)'(DEPTH));
		end
	end

	// storage write
	always_ff @(posedge clk_sys_in) begin
		if (push)
			store[wr_ptr_reg] <= in_data_in;
	end

	property p_fifo_full;
		@(posedge clk_sys_in) disable iff (!nrst_in)
		(count_reg == (AW+1)'(DEPTH)) |-> !in_ready_out;
	endproperty
	a_fifo_full: assert property (p_fifo_full)
		else $error("fifo full but ready high");
endmodule // ddrf_fifo
`default_nettype wire

// ---- logic/ddrf_top.sv ----
// device-side command capture, bank rows and burst data engine
`default_nettype none
`timescale 1ns/100ps
module ddrf_top (
	input  wire logic        clk_sys_in,
	input  wire logic        nrst_in,
	input  wire logic [9:0]  cmd_addr_rise_in,
	input  wire logic [9:0]  cmd_addr_fall_in,
	input  wire logic        org_x16_in,
	input  wire logic [1:0]  burst_len_sel_in,
	input  wire logic        burst_interleave_in,
	input  wire logic        wdata_valid_in,
	input  wire logic [31:0] wdata_rise_in,
	input  wire logic [31:0] wdata_fall_in,
	output var  logic        wdata_ready_out,
	output var  logic        rdata_valid_out,
	output var  logic [31:0] dq_rise_out,
	output var  logic [31:0] dq_fall_out,
	output var  logic        cmd_illegal_out,
	output var  logic        busy_out
);
	localparam int DW = ddrf_pkg::DQ_W;

	// burst length in columns
	function automatic logic [4:0] bl_cols(input logic [1:0] sel);
		bl_cols = (sel == ddrf_pkg::BL_4) ? 5'h04 :
		          (sel == ddrf_pkg::BL_8) ? 5'h08 : 5'h10;
	endfunction

	// column of step i in a burst, sequential or interleaved
	function automatic logic [10:0] col_at(input logic [10:0] start,
		input logic [4:0] i, input logic [4:0] bl, input logic ilv);
		logic [10:0] m;
		logic [10:0] lo;
		m  = {6'h00, bl - 5'h01};
		lo = ilv ? ((start ^ {6'h00, i}) & m) : ((start + {6'h00, i}) & m);
		col_at = (start & ~m) | lo;
	endfunction

	// shadow store index from bank, row and column
	function automatic logic [9:0] mem_idx(input logic [2:0] ba,
		input logic [13:0] row, input logic [10:0] col);
		mem_idx = {ba, row[1:0], col[4:0]};
	endfunction

	logic [DW-1:0] mem [2**ddrf_pkg::MEM_AW];
	logic [13:0]   open_row_reg [ddrf_pkg::BANKS];
	logic [7:0]    open_valid_reg;
	ddrf_pkg::ddrf_state_e state_reg;
	ddrf_pkg::ddrf_state_e state_next;
	logic [2:0]    burst_ba_reg;
	logic [10:0]   burst_col_reg;
	logic [4:0]    burst_bl_reg;
	logic          burst_ilv_reg;
	logic          burst_x16_reg;
	logic [4:0]    cnt_reg;
	logic [4:0]    cnt_next;

	// decode of the two halves of the shared bus
	wire [1:0]  op     = cmd_addr_rise_in[ddrf_pkg::OP_LSB +: ddrf_pkg::OP_W];
	wire [2:0]  ba     = cmd_addr_rise_in[ddrf_pkg::BA_LSB +: ddrf_pkg::BANK_W];
	wire [4:0]  a_hi   = cmd_addr_rise_in[ddrf_pkg::HI_LSB +: ddrf_pkg::HI_W];
	wire [13:0] act_row = {a_hi, cmd_addr_fall_in[ddrf_pkg::ROW_LO_W-1:0]};
	wire [10:0] col_raw = {a_hi, cmd_addr_fall_in[ddrf_pkg::COL_LO_W-1:0]};
	// x32 drops the top column bit; x16 keeps it
	wire [10:0] cmd_col = org_x16_in ? col_raw : {1'b0, col_raw[9:0]};
	wire        idle    = (state_reg == ddrf_pkg::DDRF_IDLE);
	wire        is_rw   = (op == ddrf_pkg::OP_RD) || (op == ddrf_pkg::OP_WR);
	// read/write only into an open bank while idle
	wire        rw_ok   = is_rw && idle && open_valid_reg[ba];
	wire        rw_bad  = is_rw && !rw_ok;
	wire        act_ok  = (op == ddrf_pkg::OP_ACT);

	// write data path through the fifo
	logic        wf_valid;
	logic [63:0] wf_data;
	wire         wr_go = (state_reg == ddrf_pkg::DDRF_WRITE) && wf_valid;
	wire         rd_go = (state_reg == ddrf_pkg::DDRF_READ);
	wire         step  = wr_go || rd_go;
	wire [2:0]   burst_row_ba = burst_ba_reg;
	wire [13:0]  burst_row = open_row_reg[burst_row_ba];
	// columns of this clock, two per clock in burst order
	wire [10:0]  col_a = col_at(burst_col_reg, cnt_reg, burst_bl_reg,
	                            burst_ilv_reg);
	wire [10:0]  col_b = col_at(burst_col_reg, cnt_reg + 5'h01,
	                            burst_bl_reg, burst_ilv_reg);
	wire [9:0]   idx_a = mem_idx(burst_ba_reg, burst_row, col_a);
	wire [9:0]   idx_b = mem_idx(burst_ba_reg, burst_row, col_b);
	wire [31:0]  lane_mask = burst_x16_reg ? 32'h0000ffff : 32'hffffffff;
	wire         last = (cnt_reg + ddrf_pkg::CNT_STEP == burst_bl_reg);

	ddrf_fifo #(
		.WIDTH (64),
		.DEPTH (ddrf_pkg::FIFO_DEPTH)
	) u_wfifo (
		.clk_sys_in    (clk_sys_in),
		.nrst_in       (nrst_in),
		.in_valid_in   (wdata_valid_in),
		.in_data_in    ({wdata_fall_in, wdata_rise_in}),
		.in_ready_out  (wdata_ready_out),
		.out_valid_out (wf_valid),
		.out_data_out  (wf_data),
		.out_ready_in  (wr_go)
	);

	// burst sequencer next state
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			ddrf_pkg::DDRF_IDLE: begin
				cnt_next = ddrf_pkg::CNT_ZERO;
				if (rw_ok)
					state_next = (op == ddrf_pkg::OP_RD) ?
						ddrf_pkg::DDRF_READ : ddrf_pkg::DDRF_WRITE;
			end
			ddrf_pkg::DDRF_READ, ddrf_pkg::DDRF_WRITE: begin
				if (step) begin
					cnt_next = cnt_reg + ddrf_pkg::CNT_STEP;
					if (last)
						state_next = ddrf_pkg::DDRF_IDLE;
				end
			end
			default: state_next = ddrf_pkg::DDRF_IDLE;
		endcase
	end

	// both halves taken in the command cycle
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg       <= ddrf_pkg::DDRF_IDLE;
			cnt_reg         <= ddrf_pkg::CNT_ZERO;
			open_valid_reg  <= 8'h00;
			burst_ba_reg    <= 3'h0;
			burst_col_reg   <= 11'h000;
			burst_bl_reg    <= 5'h04;
			burst_ilv_reg   <= 1'b0;
			burst_x16_reg   <= 1'b0;
			cmd_illegal_out <= 1'b0;
			busy_out        <= 1'b0;
		end else begin
			state_reg       <= state_next;
			cnt_reg         <= cnt_next;
			cmd_illegal_out <= rw_bad;
			busy_out        <= (state_next != ddrf_pkg::DDRF_IDLE);
			if (act_ok)
				open_valid_reg[ba] <= 1'b1;
			// bank and start column of the burst
			if (rw_ok) begin
				burst_ba_reg  <= ba;
				burst_col_reg <= cmd_col;
				burst_bl_reg  <= bl_cols(burst_len_sel_in);
				burst_ilv_reg <= burst_interleave_in;
				burst_x16_reg <= org_x16_in;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (act_ok)
			open_row_reg[ba] <= act_row;
	end

	// read data, two columns per clock on rise and fall
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_valid_out <= 1'b0;
			dq_rise_out     <= 32'h00000000;
			dq_fall_out     <= 32'h00000000;
		end else begin
			rdata_valid_out <= rd_go;
			if (rd_go) begin
				dq_rise_out <= mem[idx_a] & lane_mask;
				dq_fall_out <= mem[idx_b] & lane_mask;
			end
		end
	end

	// write two columns per clock, stall while fifo empty
	always_ff @(posedge clk_sys_in) begin
		if (wr_go) begin
			mem[idx_a] <= wf_data[31:0] & lane_mask;
			mem[idx_b] <= wf_data[63:32] & lane_mask;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	sequence s_read4;
		(op == ddrf_pkg::OP_RD) && rw_ok && (burst_len_sel_in == ddrf_pkg::BL_4);
	endsequence
	// data shows one clock after the engine reads the first pair
	sequence s_two_beats;
		##2 rdata_valid_out [*2] ##1 !rdata_valid_out;
	endsequence

	property p_act_opens;
		act_ok |=> open_valid_reg[$past(ba)] && open_row_reg[$past(ba)] == $past(act_row);
	endproperty
	a_act_opens: assert property (p_act_opens)
		else $error("activate did not open row");

	property p_closed_refused;
		(is_rw && !open_valid_reg[ba]) |=> cmd_illegal_out
			&& (!busy_out || $past(busy_out));
	endproperty
	a_closed_refused: assert property (p_closed_refused)
		else $error("access to closed bank not refused");

	property p_read4_beats;
		s_read4 |-> s_two_beats;
	endproperty
	a_read4_beats: assert property (p_read4_beats)
		else $error("burst of four not two clocks of data");

	property p_x16_lanes;
		(rdata_valid_out && burst_x16_reg) |-> (dq_rise_out[31:16] == 16'h0000
			&& dq_fall_out[31:16] == 16'h0000);
	endproperty
	a_x16_lanes: assert property (p_x16_lanes)
		else $error("x16 read drove upper lanes");

	property p_x32_col;
		(rw_ok && !org_x16_in) |=> !burst_col_reg[10];
	endproperty
	a_x32_col: assert property (p_x32_col)
		else $error("x32 column above 1023");

	property p_start_col;
		rw_ok |=> burst_col_reg == $past(cmd_col) && burst_ba_reg == $past(ba);
	endproperty
	a_start_col: assert property (p_start_col)
		else $error("burst start column or bank wrong");

	property p_wr_stall;
		(state_reg == ddrf_pkg::DDRF_WRITE && !wf_valid) |=> $stable(cnt_reg) && busy_out;
	endproperty
	a_wr_stall: assert property (p_wr_stall)
		else $error("write burst advanced without data");

	property p_nop_idle;
		(idle && op == ddrf_pkg::OP_NOP) |=> !busy_out && !cmd_illegal_out;
	endproperty
	a_nop_idle: assert property (p_nop_idle)
		else $error("no-op changed state");

	property p_ddr_pair;
		(rd_go && !last) |=> rdata_valid_out ##1 rdata_valid_out;
	endproperty
	a_ddr_pair: assert property (p_ddr_pair)
		else $error("read burst broke before its end");
endmodule // ddrf_top
`default_nettype wire

// ---- verification/ddrf_ctrl_model.sv ----
// controller model: encodes commands onto the two bus halves
`timescale 1ns/100ps
`default_nettype none
module ddrf_ctrl_model (
	input  wire logic        req_in,
	input  wire logic [1:0]  op_in,
	input  wire logic [2:0]  bank_in,
	input  wire logic [13:0] addr_in,
	output wire logic [9:0]  ca_rise_out,
	output wire logic [9:0]  ca_fall_out
);
	wire logic is_act = (op_in == ddrf_pkg::OP_ACT);
	wire logic [9:0] rise_act = {addr_in[13:9], bank_in, op_in};
	wire logic [9:0] rise_rw  = {addr_in[10:6], bank_in, op_in};
	wire logic [9:0] fall_cmd = is_act ? {1'b0, addr_in[8:0]} : {4'h0, addr_in[5:0]};
	// only defined codes, no-op when idle
	assign ca_rise_out = !req_in ? {8'h55, ddrf_pkg::OP_NOP}
		: (is_act ? rise_act : rise_rw);
	assign ca_fall_out = !req_in ? 10'h2aa : fall_cmd;
endmodule // ddrf_ctrl_model
`default_nettype wire

// ---- verification/ddr_sdram_access_framing_bench.sv ----
// self-checking bench for the access framing block
`timescale 1ns/100ps
`default_nettype none
module ddr_sdram_access_framing_bench;
	logic        clk_sys_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic        req = 1'b0, org_x16 = 1'b0, ilv = 1'b0, wvalid = 1'b0;
	logic [1:0]  op = 2'h0, bl_sel = 2'h0;
	logic [2:0]  bank = 3'h0;
	logic [13:0] addr = 14'h0;
	logic [31:0] wrise = 32'h0, wfall = 32'h0;
	wire  logic [9:0]  ca_rise, ca_fall;
	wire  logic        wready, rvalid, illegal, busy;
	wire  logic [31:0] dq_rise, dq_fall;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;

	ddrf_ctrl_model ctrl (.req_in(req), .op_in(op), .bank_in(bank),
		.addr_in(addr), .ca_rise_out(ca_rise), .ca_fall_out(ca_fall));
	ddrf_top dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
		.cmd_addr_rise_in(ca_rise), .cmd_addr_fall_in(ca_fall),
		.org_x16_in(org_x16), .burst_len_sel_in(bl_sel),
		.burst_interleave_in(ilv), .wdata_valid_in(wvalid),
		.wdata_rise_in(wrise), .wdata_fall_in(wfall),
		.wdata_ready_out(wready), .rdata_valid_out(rvalid),
		.dq_rise_out(dq_rise), .dq_fall_out(dq_fall),
		.cmd_illegal_out(illegal), .busy_out(busy));

	// 50 ns clock and a cycle ceiling against hangs
	initial begin
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles > 3000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic test_done;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick;
		@(posedge clk_sys_in);
		#1;
	endtask

	function automatic logic [31:0] pat(input int c);
		pat = {8'h5a, 8'(c), 8'ha5, 8'(c)};
	endfunction

	// one command cycle; returns one ns into the answer cycle
	// req stays high when another command follows at once
	task automatic send(input logic [1:0] o, input logic [2:0] b,
		input logic [13:0] a, input logic fin);
		op = o;
		bank = b;
		addr = a;
		req = 1'b1;
		tick();
		if (fin)
			req = 1'b0;
	endtask

	// one column pair; valid stays high inside a back-to-back run
	task automatic push(input int c, input logic fin);
		wvalid = 1'b1;
		wrise = pat(c);
		wfall = pat(c + 1);
		tick();
		if (fin)
			wvalid = 1'b0;
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 40) begin
			tick();
			n++;
		end
		chk({31'h0, busy}, 32'h0);
	endtask

	// read a burst of the bank 1 row and compare pair by pair
	task automatic t_read(input logic [1:0] sel, input logic il, input int st,
		input logic x16, input logic dbl);
		int bl;
		int c;
		logic [31:0] m;
		bl = (sel == 2'h0) ? 4 : ((sel == 2'h1) ? 8 : 16);
		m = x16 ? 32'h0000ffff : 32'hffffffff;
		bl_sel = sel;
		ilv = il;
		org_x16 = x16;
		send(ddrf_pkg::OP_RD, 3'h1, 14'(st), !dbl);
		chk({31'h0, busy}, 32'h1);
		if (dbl) begin
			send(ddrf_pkg::OP_RD, 3'h1, 14'(st), 1'b1);
			chk({31'h0, illegal}, 32'h1);
		end else
			tick();
		for (int i = 0; i < bl; i += 2) begin
			chk({31'h0, rvalid}, 32'h1);
			c = il ? (st ^ i) : ((st & ~(bl - 1)) | ((st + i) & (bl - 1)));
			chk(dq_rise & m, pat(c) & m);
			c = il ? (st ^ (i + 1))
				: ((st & ~(bl - 1)) | ((st + i + 1) & (bl - 1)));
			chk(dq_fall & m, pat(c) & m);
			tick();
		end
		chk({31'h0, rvalid}, 32'h0);
		wait_idle();
	endtask

	initial begin
		repeat (10) @(posedge clk_sys_in);
		#1;
		nrst_in = 1'b1;
		tick();
		chk({31'h0, wready}, 32'h1);
		// read of a bank never opened is refused for one cycle
		send(ddrf_pkg::OP_RD, 3'h2, 14'h0, 1'b1);
		chk({31'h0, illegal}, 32'h1);
		chk({31'h0, busy}, 32'h0);
		tick();
		chk({31'h0, illegal}, 32'h0);
		// fill the fifo until it refuses, then drain with a long write
		for (int k = 0; k < 16; k += 2)
			push(k, 1'b0);
		chk({31'h0, wready}, 32'h0);
		push(40, 1'b1);
		send(ddrf_pkg::OP_ACT, 3'h1, 14'h0005, 1'b0);
		bl_sel = 2'h2;
		send(ddrf_pkg::OP_WR, 3'h1, 14'h0000, 1'b1);
		wait_idle();
		chk({31'h0, wready}, 32'h1);
		// write whose data arrives late, engine stalls meanwhile
		bl_sel = 2'h0;
		send(ddrf_pkg::OP_WR, 3'h1, 14'h0010, 1'b1);
		repeat (3) tick();
		chk({31'h0, busy}, 32'h1);
		push(16, 1'b0);
		push(18, 1'b1);
		wait_idle();
		t_read(2'h2, 1'b0, 0, 1'b0, 1'b1);
		t_read(2'h1, 1'b1, 2, 1'b0, 1'b0);
		t_read(2'h0, 1'b0, 3, 1'b1, 1'b0);
		t_read(2'h0, 1'b1, 17, 1'b0, 1'b0);
		test_done();
	end
endmodule // ddr_sdram_access_framing_bench
`default_nettype wire
